// ---- rtl/fsm_fault_status_monitor.sv ----
// Fault and status monitor of a single-axis satellite accelerometer, APB slave
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module fsm_fault_status_monitor #(
  parameter int unsigned HoldCapLimitTicks = fsm_pkg::HOLD_CAP_TICKS,
  parameter int unsigned FrameToTicks      = fsm_pkg::FRAME_TO_TICKS,
  parameter int unsigned AccW              = 10,
  parameter int unsigned GndCntW           = fsm_pkg::GND_CNT_W
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire fsm_pkg::fsm_mon_in_t monPins,
  input  wire logic                cmdClear,
  input  wire logic                cmdDisableSt,
  input  wire logic                cmdOther,
  input  wire logic [AccW-1:0]     accelIn,
  input  wire logic [31:0]         serialNum,
  input  wire logic [7:0]          typeByte,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  output fsm_pkg::fsm_flags_t      flags_r,
  output logic [AccW-1:0]          accelOut_r,
  output logic                     busSwitchOpen_r,
  output logic                     cmdAccept_r,
  output logic                     selftestLockout_r,
  output logic                     testDataIn_r,
  output logic                     irq_r
);
  import fsm_pkg::*;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [MON_W-1:0] syncA_r;
  logic [MON_W-1:0] syncB_r;
  fsm_mon_in_t      monS;

  for (genvar i = 0; i < MON_W; i++)
  begin : g_sync
    always_ff @(posedge ref_clk or posedge rst)
    begin
      if (rst)
      begin
        syncA_r[i] <= 1'b0;
        syncB_r[i] <= 1'b0;
      end
      else
      begin
        syncA_r[i] <= monPins[i];
        syncB_r[i] <= syncA_r[i];
      end
    end
  end

  assign monS = fsm_mon_in_t'(syncB_r);

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator tick: one pulse per 4 MHz period
  logic [TICK_W-1:0] tickCnt_r;
  logic              oscTick_r;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tickCnt_r <= '0;
      oscTick_r <= 1'b0;
    end
    else if (tickCnt_r == TICK_W'(TICK_DIV - 1))
    begin
      tickCnt_r <= '0;
      oscTick_r <= 1'b1;
    end
    else
    begin
      tickCnt_r <= tickCnt_r + 1'b1;
      oscTick_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supply and frame timers, counted in oscillator ticks
  logic [TIMER_W-1:0] holdCapCnt_r;
  logic [TIMER_W-1:0] frameCnt_r;
  logic               holdCapSustained;
  logic               frameTimeout;

  assign holdCapSustained = (holdCapCnt_r == TIMER_W'(HoldCapLimitTicks));
  assign frameTimeout     = (frameCnt_r == TIMER_W'(FrameToTicks));

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      holdCapCnt_r <= '0;
    else if (!monS.holdCapLow)
      holdCapCnt_r <= '0;
    else if (oscTick_r && !holdCapSustained)
      holdCapCnt_r <= holdCapCnt_r + 1'b1;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      frameCnt_r <= '0;
    else if (!monS.busLow)
      frameCnt_r <= '0;
    else if (oscTick_r && !frameTimeout)
      frameCnt_r <= frameCnt_r + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Device reset state
  fsm_dev_state_t devState_r;
  fsm_dev_state_t devState_nxt;
  logic           resetCause;
  logic           running;

  // Cause is held as long as it lasts, so the device stays in reset until it ends
  assign resetCause = monS.regCapLow | holdCapSustained | frameTimeout;
  assign running    = (devState_r == DEV_RUN);

  always_comb
  begin
    devState_nxt = devState_r;
    unique case (devState_r)
      DEV_RUN:
        if (resetCause)
          devState_nxt = DEV_RESET;
      DEV_RESET:
        if (!resetCause)
          devState_nxt = DEV_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      devState_r      <= DEV_RESET;
      busSwitchOpen_r <= 1'b1;
      cmdAccept_r     <= 1'b0;
    end
    else
    begin
      devState_r      <= devState_nxt;
      busSwitchOpen_r <= (devState_nxt == DEV_RESET);
      cmdAccept_r     <= (devState_nxt == DEV_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Commands, self-test lockout
  logic clearOk;
  logic disableOk;
  logic otherOk;
  logic prevDisable_r;

  assign clearOk   = cmdClear & running;
  assign disableOk = cmdDisableSt & running;
  assign otherOk   = cmdOther & running;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      prevDisable_r     <= 1'b0;
      selftestLockout_r <= 1'b0;
    end
    else if (!running)
    begin
      prevDisable_r     <= 1'b0;
      selftestLockout_r <= 1'b0;
    end
    else
    begin
      if (disableOk)
        prevDisable_r <= 1'b1;
      else if (otherOk || clearOk)
        prevDisable_r <= 1'b0;
      if (disableOk && prevDisable_r)
        selftestLockout_r <= 1'b1;
      else if (clearOk)
        selftestLockout_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ground-loss filter
  logic [7:0]           cfgByte_r;
  logic                 gldEnable;
  logic [GndCntW-1:0]   filtCount;
  logic                 gndAtMax;

  // Test mode takes the pin away from the detector
  assign gldEnable = cfgByte_r[CFG_GLD_EN_BIT] & ~monS.diffMode & ~monS.testMode;

  fsm_gnd_filter #(
    .W      (GndCntW)
  ) u_gnd_filter (
    .ref_clk(ref_clk),
    .rst    (rst),
    .clear  (!running),
    .tick   (oscTick_r),
    .enable (gldEnable),
    .openIn (monS.gndOpen),
    .count  (filtCount),
    .atMax  (gndAtMax)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Fault latches; set wins over Clear and release, but device reset clears both
  logic gndFaultLatch_r;
  logic statusLatch_r;
  logic statusCond;

  assign statusCond = gndAtMax | monS.fuseFault | monS.parFactory | monS.parCustomer;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      gndFaultLatch_r <= 1'b0;
      statusLatch_r   <= 1'b0;
    end
    else if (!running)
    begin
      gndFaultLatch_r <= 1'b0;
      statusLatch_r   <= 1'b0;
    end
    else
    begin
      if (gndAtMax)
        gndFaultLatch_r <= 1'b1;
      else if (clearOk || (!selftestLockout_r && !gndAtMax))
        gndFaultLatch_r <= 1'b0;
      if (statusCond)
        statusLatch_r <= 1'b1;
      else if (clearOk || !selftestLockout_r)
        statusLatch_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags, acceleration response, test data
  fsm_flags_t flagsNxt;

  always_comb
  begin
    flagsNxt             = '0;
    flagsNxt.inReset     = !running;
    // Any reset cause outranks the transient dip flag
    flagsNxt.underVolt   = running & ~resetCause & monS.holdCapLow;
    flagsNxt.accelStatus = statusLatch_r;
    flagsNxt.groundFault = gndFaultLatch_r;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      flags_r      <= '0;
      accelOut_r   <= '0;
      testDataIn_r <= 1'b0;
    end
    else
    begin
      flags_r <= flagsNxt;
      // No data leaves the block while reset is held
      if (flagsNxt.inReset || flagsNxt.underVolt || flagsNxt.accelStatus || flagsNxt.groundFault)
        accelOut_r <= '0;
      else
        accelOut_r <= accelIn;
      testDataIn_r <= monS.testMode & monS.gndOpen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts
  logic [FLAG_W-1:0] irqStat_r;
  logic [FLAG_W-1:0] irqEn_r;
  logic [FLAG_W-1:0] irqEvent;
  logic [FLAG_W-1:0] irqClr;
  logic              apbWrite;
  logic              apbRead;

  assign irqEvent = flagsNxt & ~flags_r;
  assign irqClr   = (apbWrite && paddr == ADDR_IRQ_CLR) ? pwdata[FLAG_W-1:0] : '0;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      irqStat_r <= '0;
      irq_r     <= 1'b0;
    end
    else
    begin
      irqStat_r <= (irqStat_r & ~irqClr) | irqEvent;
      irq_r     <= |(irqStat_r & irqEn_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, registered answer
  logic [31:0] rdData;
  logic        rdErr;

  assign apbWrite = psel & penable & pready & pwrite;
  assign apbRead  = psel & penable & ~pready & ~pwrite;

  always_comb
  begin
    rdData = '0;
    rdErr  = 1'b0;
    case (paddr)
      ADDR_CFG_BYTE_TWO: rdData = 32'(cfgByte_r);
      ADDR_STATUS:       rdData = 32'({selftestLockout_r, flags_r});
      ADDR_IRQ_STAT:     rdData = 32'(irqStat_r);
      ADDR_IRQ_CLR:      rdData = '0;
      ADDR_IRQ_EN:       rdData = 32'(irqEn_r);
      ADDR_SERIAL:       rdData = serialNum;
      ADDR_TYPE:         rdData = 32'(typeByte);
      ADDR_FILT_CNT:     rdData = 32'(filtCount);
      default:           rdErr  = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & rdErr;
      if (apbRead)
        prdata <= rdData;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cfgByte_r <= CFG_RESET;
      irqEn_r   <= IRQ_EN_RESET;
    end
    else if (apbWrite)
    begin
      if (paddr == ADDR_CFG_BYTE_TWO)
        cfgByte_r <= pwdata[7:0];
      if (paddr == ADDR_IRQ_EN)
        irqEn_r <= pwdata[FLAG_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_gld_disabled_idle: assert property (
    !gldEnable |=> filtCount == '0 && !gndAtMax)
    else $error("filter counter moved while detection disabled");

  a_diff_mode_off: assert property (
    monS.diffMode ##1 monS.diffMode |-> filtCount == '0)
    else $error("ground detection active in differential mode");

  a_filter_counts_up: assert property (
    running && gldEnable && monS.gndOpen && oscTick_r && filtCount != '1 && devState_nxt == DEV_RUN
    |=> filtCount == $past(filtCount) + 1'b1)
    else $error("filter counter did not count up");

  a_filter_counts_down: assert property (
    running && gldEnable && !monS.gndOpen && oscTick_r && filtCount != '0 && devState_nxt == DEV_RUN
    |=> filtCount == $past(filtCount) - 1'b1)
    else $error("filter counter did not count down");

  a_gnd_overflow_cause: assert property (
    $rose(flags_r.groundFault) |-> $past(gndAtMax, 2))
    else $error("ground fault without filter overflow");

  a_gnd_fault_effect: assert property (
    flags_r.groundFault |-> flags_r.accelStatus && accelOut_r == '0)
    else $error("ground fault without status flag or zero data");

  a_tick_period: assert property (
    oscTick_r |=> !oscTick_r [*8])
    else $error("oscillator tick too frequent");

  a_regcap_reset: assert property (
    monS.regCapLow |=> busSwitchOpen_r && !cmdAccept_r ##1 flags_r.inReset)
    else $error("regulator undervoltage did not hold reset");

  a_holdcap_reset: assert property (
    holdCapSustained |=> busSwitchOpen_r && !cmdAccept_r)
    else $error("sustained supply dip did not reset");

  a_frame_timeout: assert property (
    frameTimeout |=> busSwitchOpen_r)
    else $error("frame timeout did not reset");

  a_uv_zero_data: assert property (
    flags_r.underVolt |-> accelOut_r == '0 && !busSwitchOpen_r)
    else $error("transient undervoltage handled wrongly");

  a_fuse_status: assert property (
    running && monS.fuseFault && devState_nxt == DEV_RUN |=> ##1 flags_r.accelStatus && accelOut_r == '0)
    else $error("fuse fault did not set status");

  a_parity_status: assert property (
    running && (monS.parFactory || monS.parCustomer) && devState_nxt == DEV_RUN
    |=> ##1 flags_r.accelStatus)
    else $error("parity fault did not set status");

  a_lockout_set: assert property (
    $rose(selftestLockout_r) |-> $past(disableOk) && $past(prevDisable_r))
    else $error("lockout set without two disable commands");

  a_lockout_holds: assert property (
    running && selftestLockout_r && gndFaultLatch_r && !clearOk && devState_nxt == DEV_RUN |=> gndFaultLatch_r)
    else $error("locked fault cleared without Clear");

  a_status_held_locked: assert property (
    running && selftestLockout_r && statusLatch_r && !clearOk && devState_nxt == DEV_RUN |=> statusLatch_r)
    else $error("locked status cleared without Clear");

  a_test_data_in: assert property (
    monS.testMode |=> testDataIn_r == $past(monS.gndOpen))
    else $error("test data input not routed");

  a_filter_floor: assert property (
    filtCount == '0 && !monS.gndOpen |=> filtCount == '0)
    else $error("filter counter wrapped below zero");

endmodule : fsm_fault_status_monitor

// ---- rtl/fsm_pkg.sv ----
// Package: constants, register map and types of the fault and status monitor
package fsm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clocking and timing
  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned OSC_HZ           = 4_000_000;
  localparam int unsigned TICK_DIV         = CLK_HZ / OSC_HZ;
  localparam int unsigned TICK_W           = 5;
  localparam int unsigned HOLD_CAP_LIMIT_US = 1000;
  localparam int unsigned HOLD_CAP_TICKS   = HOLD_CAP_LIMIT_US * (OSC_HZ / 1_000_000);
  localparam int unsigned FRAME_TO_US      = 1000;
  localparam int unsigned FRAME_TO_TICKS   = FRAME_TO_US * (OSC_HZ / 1_000_000);
  localparam int unsigned TIMER_W          = 16;
  localparam int unsigned GND_CNT_W        = 14;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses) and fields
  localparam logic [7:0] ADDR_CFG_BYTE_TWO = 8'h00;
  localparam logic [7:0] ADDR_STATUS       = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT     = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CLR      = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_EN       = 8'h10;
  localparam logic [7:0] ADDR_SERIAL       = 8'h14;
  localparam logic [7:0] ADDR_TYPE         = 8'h18;
  localparam logic [7:0] ADDR_FILT_CNT     = 8'h1C;
  localparam logic [7:0] CFG_RESET         = 8'h00;
  localparam int unsigned CFG_GLD_EN_BIT   = 5;
  localparam logic [3:0] IRQ_EN_RESET      = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic gndOpen;
    logic holdCapLow;
    logic regCapLow;
    logic busLow;
    logic fuseFault;
    logic parFactory;
    logic parCustomer;
    logic testMode;
    logic diffMode;
  } fsm_mon_in_t;

  localparam int unsigned MON_W = $bits(fsm_mon_in_t);

  // Bit order is also the interrupt status layout
  typedef struct packed {
    logic inReset;
    logic underVolt;
    logic accelStatus;
    logic groundFault;
  } fsm_flags_t;

  localparam int unsigned FLAG_W = $bits(fsm_flags_t);

  typedef enum logic {DEV_RUN, DEV_RESET} fsm_dev_state_t;

endpackage : fsm_pkg

// ---- rtl/fsm_gnd_filter.sv ----
// Up/down digital filter counter qualifying the ground-loss comparator
`timescale 1ns/1ns
module fsm_gnd_filter #(
  parameter int unsigned W = fsm_pkg::GND_CNT_W
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         clear,
  input  wire logic         tick,
  input  wire logic         enable,
  input  wire logic         openIn,
  output logic [W-1:0]      count,
  output logic              atMax
);
  import fsm_pkg::*;

  localparam logic [W-1:0] CNT_MAX = '1;

  logic [W-1:0] count_nxt;

  always_comb
  begin
    count_nxt = count;
    if (clear || !enable)
      count_nxt = '0;
    else if (tick && openIn && count != CNT_MAX)
      count_nxt = count + 1'b1;
    else if (tick && !openIn && count != '0)
      count_nxt = count - 1'b1;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      count <= '0;
      atMax <= 1'b0;
    end
    else
    begin
      count <= count_nxt;
      atMax <= (count_nxt == CNT_MAX);
    end
  end

endmodule : fsm_gnd_filter

// ---- verification/fsm_dsi_master.sv ----
// Bus master model that issues one-cycle command pulses to the monitor
`timescale 1ns/1ns
module fsm_dsi_master (
  input  wire logic ref_clk,
  output logic      cmdClear,
  output logic      cmdDisableSt,
  output logic      cmdOther
);
  initial
  begin
    cmdClear     = 1'b0;
    cmdDisableSt = 1'b0;
    cmdOther     = 1'b0;
  end

  // Kind 0 clear, 1 disable self-test, 2 any other; gap sets how slowly the next command follows
  task automatic send(input int kind, input int gap);
    @(posedge ref_clk);
    cmdClear     <= (kind == 0);
    cmdDisableSt <= (kind == 1);
    cmdOther     <= (kind == 2);
    @(posedge ref_clk);
    cmdClear     <= 1'b0;
    cmdDisableSt <= 1'b0;
    cmdOther     <= 1'b0;
    repeat (gap) @(posedge ref_clk);
  endtask : send
endmodule : fsm_dsi_master

// ---- verification/testbench.sv ----
// Self-checking bench of the fault and status monitor
`timescale 1ns/1ns
module testbench;
  import fsm_pkg::*;
  typedef struct packed {logic [31:0] data; logic [31:0] mask; logic err;} fsm_exp_t;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  fsm_mon_in_t monPins = '0;
  logic [9:0]  accelIn = '0;
  logic [31:0] serialNum = '0;
  logic [7:0]  typeByte = '0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready, pslverr, busSwitchOpen_r, cmdAccept_r, selftestLockout_r, testDataIn_r, irq_r;
  logic        cmdClear, cmdDisableSt, cmdOther;
  fsm_flags_t  flags_r;
  logic [9:0]  accelOut_r, aExp;
  logic [31:0] lastRd;
  fsm_exp_t    monE;
  fsm_exp_t    expQ[$];
  logic [10:0] accQ[$];
  logic        aSkip;
  int          mismatches = 0;
  int          totalChecks = 0;
  int          cycles = 0;

  always #5 ref_clk = ~ref_clk;

  // Short supply and frame limits keep the reset scenarios brief; a narrow filter reaches overflow
  fsm_fault_status_monitor #(.HoldCapLimitTicks(4), .FrameToTicks(4), .AccW(10), .GndCntW(6)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .monPins(monPins), .cmdClear(cmdClear), .cmdDisableSt(cmdDisableSt),
    .cmdOther(cmdOther), .accelIn(accelIn), .serialNum(serialNum), .typeByte(typeByte), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flags_r(flags_r), .accelOut_r(accelOut_r), .busSwitchOpen_r(busSwitchOpen_r),
    .cmdAccept_r(cmdAccept_r), .selftestLockout_r(selftestLockout_r), .testDataIn_r(testDataIn_r),
    .irq_r(irq_r));

  fsm_dsi_master u_master (.ref_clk(ref_clk), .cmdClear(cmdClear), .cmdDisableSt(cmdDisableSt),
    .cmdOther(cmdOther));

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic ok, input string msg);
    totalChecks++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wt

  // Expectation is queued first; the monitor judges the answer when pready comes
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input fsm_exp_t e);
    int n;
    n = 0;
    expQ.push_back(e);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    lastRd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n < 50, "bus transfer never completed");
  endtask : xfer

  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m, input logic err);
    xfer(1'b0, a, 32'h0000_0000, '{v, m, err});
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, '{32'h0000_0000, 32'h0000_0000, 1'b0});
  endtask : wr

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      report_and_stop();
    end
    if (psel && penable && pready === 1'b1 && expQ.size() > 0)
    begin
      monE = expQ.pop_front();
      chk(((prdata & monE.mask) === monE.data) && (pslverr === monE.err), "bus answer differs");
    end
    accQ.push_back({rst, accelIn});
    accelIn <= 10'($urandom);
  end

  // Any raised flag must blank the acceleration word in the same cycle
  always @(negedge ref_clk)
    if (accQ.size() > 0)
    begin
      // Words taken while reset was sampled are not judged
      {aSkip, aExp} = accQ.pop_front();
      if (flags_r !== '0)
        aExp = '0;
      if (!aSkip)
        chk(accelOut_r === aExp, "acceleration word differs");
    end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int prevCnt;
    void'($urandom(32'h7ca6_90e3));
    serialNum = $urandom;
    typeByte = 8'($urandom);
    wt(5);
    rst <= 1'b0;
    wt(3);
    rd(ADDR_CFG_BYTE_TWO, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0);
    rd(ADDR_IRQ_EN, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0);
    rd(ADDR_SERIAL, serialNum, 32'hFFFF_FFFF, 1'b0);
    rd(ADDR_TYPE, {24'h00_0000, typeByte}, 32'hFFFF_FFFF, 1'b0);
    rd(8'h20, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
    wr(ADDR_STATUS, 32'hFFFF_FFFF);
    rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_001F, 1'b0);
    // Ground-loss filter: disabled, counting up, counting down, floor at zero, overflow
    monPins.gndOpen <= 1'b1;
    wt(250);
    rd(ADDR_FILT_CNT, 32'h0000_0000, 32'h0000_3FFF, 1'b0);
    wr(ADDR_CFG_BYTE_TWO, 32'h0000_0020);
    wt(250);
    rd(ADDR_FILT_CNT, 32'h0000_0000, 32'h0000_0000, 1'b0);
    prevCnt = int'(lastRd[13:0]);
    chk(prevCnt >= 9 && prevCnt <= 12, "filter count up");
    monPins.gndOpen <= 1'b0;
    wt(100);
    rd(ADDR_FILT_CNT, 32'h0000_0000, 32'h0000_0000, 1'b0);
    chk(int'(lastRd[13:0]) < prevCnt && lastRd[13:0] != 14'h0000, "filter count down");
    wt(400);
    rd(ADDR_FILT_CNT, 32'h0000_0000, 32'h0000_3FFF, 1'b0);
    monPins.gndOpen <= 1'b1;
    wt(1500);
    chk(flags_r.groundFault === 1'b0, "ground fault before overflow");
    wt(150);
    chk(flags_r.groundFault === 1'b1 && flags_r.accelStatus === 1'b1, "ground fault");
    monPins.gndOpen <= 1'b0;
    wt(40);
    chk(flags_r.groundFault === 1'b0 && flags_r.accelStatus === 1'b0, "ground fault release");
    monPins.diffMode <= 1'b1;
    monPins.gndOpen <= 1'b1;
    wt(250);
    rd(ADDR_FILT_CNT, 32'h0000_0000, 32'h0000_3FFF, 1'b0);
    monPins.diffMode <= 1'b0;
    monPins.testMode <= 1'b1;
    wt(4);
    chk(testDataIn_r === 1'b1, "test data high");
    monPins.gndOpen <= 1'b0;
    wt(4);
    chk(testDataIn_r === 1'b0, "test data low");
    monPins.testMode <= 1'b0;
    // Fuse and parity faults, with the interrupt raised, cleared and masked
    wr(ADDR_IRQ_EN, 32'h0000_0002);
    wr(ADDR_IRQ_CLR, 32'h0000_000F);
    for (int i = 2; i <= 4; i++)
    begin
      monPins[i] <= 1'b1;
      wt(6);
      chk(flags_r.accelStatus === 1'b1 && irq_r === 1'b1, "fault flag");
      monPins[i] <= 1'b0;
      wt(5);
      chk(flags_r.accelStatus === 1'b0 && irq_r === 1'b1, "fault release");
    end
    rd(ADDR_IRQ_STAT, 32'h0000_0002, 32'h0000_000F, 1'b0);
    wr(ADDR_IRQ_CLR, 32'h0000_0002);
    wt(2);
    chk(irq_r === 1'b0, "interrupt cleared");
    wr(ADDR_IRQ_EN, 32'h0000_0000);
    monPins.fuseFault <= 1'b1;
    wt(5);
    chk(irq_r === 1'b0, "interrupt masked");
    monPins.fuseFault <= 1'b0;
    // Self-test lockout holds a fault until Clear
    u_master.send(1, 4);
    u_master.send(1, 0);
    wt(1);
    chk(selftestLockout_r === 1'b1, "lockout set");
    rd(ADDR_STATUS, 32'h0000_0010, 32'h0000_0010, 1'b0);
    monPins.fuseFault <= 1'b1;
    wt(5);
    monPins.fuseFault <= 1'b0;
    wt(5);
    chk(flags_r.accelStatus === 1'b1, "fault held under lockout");
    u_master.send(0, 2);
    chk(flags_r.accelStatus === 1'b0 && selftestLockout_r === 1'b0, "clear command");
    u_master.send(1, 2);
    u_master.send(2, 2);
    u_master.send(1, 2);
    chk(selftestLockout_r === 1'b0, "broken pair");
    // Supply and frame faults: short dip flags only, long causes hold the device in reset
    monPins.holdCapLow <= 1'b1;
    wt(50);
    chk(flags_r.underVolt === 1'b1 && busSwitchOpen_r === 1'b0, "transient dip");
    monPins.holdCapLow <= 1'b0;
    wt(5);
    for (int i = 5; i <= 7; i++)
    begin
      monPins[i] <= 1'b1;
      wt(200);
      u_master.send(1, 0);
      u_master.send(1, 0);
      chk(busSwitchOpen_r === 1'b1 && cmdAccept_r === 1'b0 && selftestLockout_r === 1'b0, "held");
      monPins[i] <= 1'b0;
      wt(10);
      chk(busSwitchOpen_r === 1'b0 && cmdAccept_r === 1'b1, "reset exit");
    end
    report_and_stop();
  end
endmodule : testbench
